// ==== verilog/cbbs_consts.svh ====
`ifndef CBBS_CONSTS_SVH
`define CBBS_CONSTS_SVH

// Octets in one broadcast block and the index of its last octet
`define CBBS_BLK_OCTETS 23
`define CBBS_LAST_OCTET 5'h16
// Blocks per message and the last block number
`define CBBS_LAST_BLK 2'h3
// Frames per control multiframe and the block index modulus
`define CBBS_FN_PER_MF 51
`define CBBS_TB_MOD 8
// Highest block index that may carry data
`define CBBS_TB_LAST_TX 3'h3
// Frame offset in the multiframe where a broadcast block begins
`define CBBS_SLOT_FN 6'h08
// Sequence numbers carried in the message type octet
`define CBBS_SEQ_FIRST 4'h0
`define CBBS_SEQ_FILL 4'hf
// Fill frame octets
`define CBBS_FILL_TYPE 8'h0f
`define CBBS_FILL_PAD 8'h2b
// Dedicated control sub-channel availability masks
`define CBBS_SUBCH_ALL 8'hff
`define CBBS_SUBCH_CBCH 8'hfb
`define CBBS_SUBCH_BCAST 2

`endif

// ==== verilog/cbbs_pkg.sv ====
package cbbs_pkg;
  // One octet of a broadcast request from the controller
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } cbbs_req_t;
  // One octet on the broadcast channel
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic fill;
    logic [7:0] data;
  } cbbs_tx_t;
  typedef enum logic [0:0] {CBBS_IDLE, CBBS_SEND} cbbs_txst_t;
endpackage

// ==== verilog/cbbs_mem.sv ====
`timescale 1ns/1ps
module cbbs_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [DW-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (ce_in && wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// ==== verilog/cbbs_top.sv ====
// How it works
// - Each request block is sent unchanged, 23 octets.
// - Message starts only after four blocks held.
// - Block sequence numbers must arrive 0,1,2,3.
// - Sequence 0 block begins a new message.
// - Message blocks go out at indices 0..3.
// - Fill frame sent when no message ready.
// - Silence at block indices 4 to 7.
// - Block index is frame number div 51 mod 8.
// - Fill is type octet F then 22 x 2B.
// - Two complete messages buffered at once.
// - Sub-channel 2 withheld while broadcast enabled.
`timescale 1ns/1ps
`include "cbbs_consts.svh"
module cbbs_top #(
  parameter int FN_W = 22,
  parameter logic [5:0] SLOT_FN = `CBBS_SLOT_FN
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic broadcast_channel_indicator_in,
  input wire cbbs_pkg::cbbs_req_t req_in,
  output logic req_ready_out,
  input wire logic fn_strobe_in,
  input wire logic [FN_W-1:0] fn_in,
  output cbbs_pkg::cbbs_tx_t tx_out,
  output logic seq_err_out,
  output logic msg_done_out,
  output logic [7:0] subch_avail_out
);
  import cbbs_pkg::*;

  function automatic logic [2:0] tb_of(input logic [FN_W-1:0] fn);
    logic [FN_W-1:0] q;
    q = fn / FN_W'(`CBBS_FN_PER_MF);
    return q[2:0];
  endfunction

  function automatic logic [5:0] fn_ofs(input logic [FN_W-1:0] fn);
    logic [FN_W-1:0] r;
    r = fn % FN_W'(`CBBS_FN_PER_MF);
    return r[5:0];
  endfunction

  logic rst_meta, rst_sync;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Assembly side
  logic [1:0] full, next_full;
  logic wr_slot, wr_active, in_blk;
  logic [1:0] wr_blk, w_blk;
  logic [4:0] wr_idx, w_idx;
  logic [3:0] seq;
  logic acc, seq_ok, wr_en, blk_end, msg_end, seq_bad;
  logic next_wr_slot, tx_clr, rd_slot;

  always_comb begin
    seq = req_in.data[3:0];
    acc = req_in.valid && req_ready_out;
    seq_ok = seq == `CBBS_SEQ_FIRST || (wr_active && seq == {2'h0, wr_blk});
    w_blk = (req_in.first && seq == `CBBS_SEQ_FIRST) ? 2'h0 : wr_blk;
    w_idx = req_in.first ? 5'h00 : wr_idx;
    wr_en = acc && (req_in.first ? seq_ok : in_blk);
    seq_bad = acc && req_in.first && !seq_ok;
    blk_end = wr_en && w_idx == `CBBS_LAST_OCTET;
    msg_end = blk_end && w_blk == `CBBS_LAST_BLK;
    next_full = full;
    if (tx_clr) begin
      next_full[rd_slot] = 1'b0;
    end
    if (msg_end) begin
      next_full[wr_slot] = 1'b1;
    end
    next_wr_slot = msg_end ? !wr_slot : wr_slot;
  end

  always_ff @(posedge core_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      full <= 2'h0;
      wr_slot <= 1'b0;
      req_ready_out <= 1'b0;
    end else if (ce_in) begin
      full <= next_full;
      wr_slot <= next_wr_slot;
      req_ready_out <= !next_full[next_wr_slot];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      wr_active <= 1'b0;
      in_blk <= 1'b0;
      wr_blk <= 2'h0;
      wr_idx <= 5'h00;
      seq_err_out <= 1'b0;
    end else if (ce_in) begin
      seq_err_out <= seq_bad;
      if (seq_bad) begin
        wr_active <= 1'b0;
        in_blk <= 1'b0;
        wr_blk <= 2'h0;
        wr_idx <= 5'h00;
      end else if (wr_en) begin
        if (req_in.first) begin
          wr_active <= 1'b1;
          in_blk <= 1'b1;
          wr_blk <= w_blk;
        end
        wr_idx <= w_idx + 5'h01;
        if (blk_end) begin
          in_blk <= 1'b0;
          wr_idx <= 5'h00;
          wr_blk <= w_blk + 2'h1;
          if (msg_end) begin
            wr_active <= 1'b0;
            wr_blk <= 2'h0;
          end
        end
      end
    end
  end

  // Transmit side
  cbbs_txst_t st;
  logic [2:0] tb_now, tb_q;
  logic [1:0] cur_blk;
  logic [4:0] rd_idx;
  logic sending, cur_fill, slot_go, use_msg, blk_done;
  logic [7:0] mem_q;
  logic p_v, p_first, p_last, p_fill;

  always_comb begin
    tb_now = tb_of(fn_in);
    slot_go = fn_strobe_in && fn_ofs(fn_in) == SLOT_FN && broadcast_channel_indicator_in &&
      tb_now <= `CBBS_TB_LAST_TX && st == CBBS_IDLE;
    use_msg = (tb_now == 3'h0) ? full[rd_slot] : sending;
    blk_done = st == CBBS_SEND && rd_idx == `CBBS_LAST_OCTET;
    tx_clr = blk_done && !cur_fill && cur_blk == `CBBS_LAST_BLK;
  end

  always_ff @(posedge core_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= CBBS_IDLE;
      sending <= 1'b0;
      rd_slot <= 1'b0;
      cur_fill <= 1'b1;
      cur_blk <= 2'h0;
      rd_idx <= 5'h00;
      tb_q <= 3'h0;
      msg_done_out <= 1'b0;
    end else if (ce_in) begin
      msg_done_out <= tx_clr;
      if (slot_go) begin
        st <= CBBS_SEND;
        tb_q <= tb_now;
        sending <= use_msg;
        cur_fill <= !use_msg;
        cur_blk <= tb_now[1:0];
        rd_idx <= 5'h00;
      end else if (blk_done) begin
        st <= CBBS_IDLE;
        if (tx_clr) begin
          sending <= 1'b0;
          rd_slot <= !rd_slot;
        end
      end else if (st == CBBS_SEND) begin
        rd_idx <= rd_idx + 5'h01;
      end
    end
  end

  cbbs_mem #(.AW(8), .DW(8)) u_mem (
    .clk_in(core_clk_in),
    .ce_in(ce_in),
    .wr_en_in(wr_en),
    .wr_addr_in({wr_slot, w_blk, w_idx}),
    .wr_data_in(req_in.data),
    .rd_addr_in({rd_slot, cur_blk, rd_idx}),
    .rd_data_out(mem_q)
  );

  always_ff @(posedge core_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      p_v <= 1'b0;
      p_first <= 1'b0;
      p_last <= 1'b0;
      p_fill <= 1'b0;
      tx_out <= '0;
    end else if (ce_in) begin
      p_v <= st == CBBS_SEND;
      p_first <= st == CBBS_SEND && rd_idx == 5'h00;
      p_last <= blk_done;
      p_fill <= cur_fill;
      tx_out.valid <= p_v;
      tx_out.first <= p_v && p_first;
      tx_out.last <= p_v && p_last;
      tx_out.fill <= p_v && p_fill;
      if (!p_v) begin
        tx_out.data <= 8'h00;
      end else if (p_fill) begin
        tx_out.data <= p_first ? `CBBS_FILL_TYPE : `CBBS_FILL_PAD;
      end else begin
        tx_out.data <= mem_q;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      subch_avail_out <= `CBBS_SUBCH_ALL;
    end else if (ce_in) begin
      subch_avail_out <= broadcast_channel_indicator_in ? `CBBS_SUBCH_CBCH : `CBBS_SUBCH_ALL;
    end
  end

  // Checks
  sequence s_block_body;
    tx_out.valid [*8] ##1 tx_out.valid [*8] ##1 tx_out.valid [*7];
  endsequence

  property p_block_len;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_out.first |-> s_block_body ##0 tx_out.last;
  endproperty
  a_block_len: assert property (p_block_len) else $error("block not 23 octets");

  property p_fill_type;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_out.first && tx_out.fill |-> tx_out.data[3:0] == `CBBS_SEQ_FILL;
  endproperty
  a_fill_type: assert property (p_fill_type) else $error("fill type octet wrong");

  property p_fill_pad;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_out.valid && tx_out.fill && !tx_out.first |-> tx_out.data == `CBBS_FILL_PAD;
  endproperty
  a_fill_pad: assert property (p_fill_pad) else $error("fill pad octet wrong");

  property p_silent;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_out.first |-> tb_q <= `CBBS_TB_LAST_TX;
  endproperty
  a_silent: assert property (p_silent) else $error("sent in silent block");

  property p_blk_match;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_out.first && !tx_out.fill |-> cur_blk == tb_q[1:0] && sending;
  endproperty
  a_blk_match: assert property (p_blk_match) else $error("block index mismatch");

  property p_start_full;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      slot_go && tb_now == 3'h0 && use_msg |-> full[rd_slot];
  endproperty
  a_start_full: assert property (p_start_full) else $error("message started early");

  property p_no_overrun;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      wr_en |-> !full[wr_slot];
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("write into full slot");

  property p_drop;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      seq_bad |=> !wr_active && seq_err_out && wr_blk == 2'h0;
  endproperty
  a_drop: assert property (p_drop) else $error("partial message kept");

  property p_mask;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      broadcast_channel_indicator_in |=> !subch_avail_out[`CBBS_SUBCH_BCAST];
  endproperty
  a_mask: assert property (p_mask) else $error("sub-channel 2 offered");

  property p_order;
    @(posedge core_clk_in) disable iff (!rst_sync || !ce_in)
      tx_clr |=> rd_slot != $past(rd_slot);
  endproperty
  a_order: assert property (p_order) else $error("slot order broken");
endmodule

// ==== dv/cbbs_ctrl_model.sv ====
`timescale 1ns/1ps
module cbbs_ctrl_model (
  input wire logic core_clk_in,
  input wire logic req_ready_in,
  output cbbs_pkg::cbbs_req_t req_out
);
  import cbbs_pkg::*;
  // Reserved access grant blocks the controller configures, kept above zero
  localparam int RSV_GRANT_BLKS = 1;
  initial begin
    req_out = '0;
  end
  // Octet k of block seq of message id; octet 0 is the type octet
  function automatic logic [7:0] oct(input logic [3:0] id, input logic [3:0] seq, input int k);
    oct = (k == 0) ? {id, seq} : 8'(k * 7 + seq * 3 + id * 16);
  endfunction
  task automatic send_block(input logic [3:0] id, input logic [3:0] seq);
    for (int k = 0; k < 23; k++) begin
      @(negedge core_clk_in);
      req_out.valid = 1'b1;
      req_out.first = (k == 0);
      req_out.data = oct(id, seq, k);
      // Hold the octet until it is sampled with ready high
      while (req_ready_in !== 1'b1) @(negedge core_clk_in);
      @(posedge core_clk_in);
    end
    @(negedge core_clk_in);
    req_out.valid = 1'b0;
    req_out.first = 1'b0;
    // Released lines do not keep the last value
    req_out.data = ~req_out.data;
  endtask
endmodule

// ==== dv/cbbs_top_tb.sv ====
`timescale 1ns/1ps
module cbbs_top_tb;
  import cbbs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ind = 1'b1;
  logic fn_strobe = 1'b0;
  logic [21:0] fn = '0;
  cbbs_req_t req;
  logic req_ready;
  cbbs_tx_t tx;
  logic seq_err;
  logic msg_done;
  logic [7:0] subch;
  int n_errors = 0;
  int comparisons = 0;
  int n_seq_err = 0;

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  cbbs_top uut (
    .core_clk_in(core_clk),
    .rst_n_in(rst_n),
    .ce_in(1'b1),
    .broadcast_channel_indicator_in(ind),
    .req_in(req),
    .req_ready_out(req_ready),
    .fn_strobe_in(fn_strobe),
    .fn_in(fn),
    .tx_out(tx),
    .seq_err_out(seq_err),
    .msg_done_out(msg_done),
    .subch_avail_out(subch)
  );

  cbbs_ctrl_model u_ctrl (
    .core_clk_in(core_clk),
    .req_ready_in(req_ready),
    .req_out(req)
  );

  always @(posedge core_clk) begin
    if (seq_err === 1'b1) begin
      n_seq_err++;
    end
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      $display("mismatch at %0t: %s", $time, msg);
      n_errors++;
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Strobe one frame number; mode 0 expects fill, 1 a message block, 2 silence
  task automatic tx_check(input int f, input int mode, input logic [3:0] id,
                          input logic [3:0] seq);
    logic [7:0] exp;
    logic on;
    @(negedge core_clk);
    fn_strobe = 1'b1;
    fn = 22'(f);
    @(negedge core_clk);
    fn_strobe = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int k = 0; k < 24; k++) begin
      on = (mode != 2) && (k < 23);
      exp = (mode == 1) ? u_ctrl.oct(id, seq, k) : ((k == 0) ? 8'h0f : 8'h2b);
      chk(tx.valid === on, "broadcast valid");
      if (on) begin
        chk(tx.data === exp && tx.fill === (mode == 0), "broadcast octet");
        chk(tx.first === (k == 0) && tx.last === (k == 22), "block framing");
      end
      if (mode == 1 && seq == 4'h3 && k == 21) begin
        chk(msg_done === 1'b1, "message done pulse");
      end
      @(negedge core_clk);
    end
  endtask

  task automatic t_idle;
    chk(subch === 8'hfb, "sub-channel mask enabled");
    tx_check(8, 0, 4'h0, 4'h0);
    tx_check(4 * 51 + 8, 2, 4'h0, 4'h0);
    tx_check(7 * 51 + 8, 2, 4'h0, 4'h0);
    tx_check(9, 2, 4'h0, 4'h0);
    ind = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(subch === 8'hff, "sub-channel mask disabled");
    ind = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask

  task automatic t_seq_err;
    u_ctrl.send_block(4'h3, 4'h0);
    u_ctrl.send_block(4'h3, 4'h2);
    repeat (2) @(negedge core_clk);
    chk(n_seq_err == 1, "order error pulse");
    tx_check(8 * 51 + 8, 0, 4'h0, 4'h0);
  endtask

  task automatic t_two_msgs;
    u_ctrl.send_block(4'h5, 4'h0);
    u_ctrl.send_block(4'h5, 4'h1);
    for (int m = 1; m < 3; m++)
      for (int s = 0; s < 4; s++)
        u_ctrl.send_block(4'(m), 4'(s));
    repeat (2) @(negedge core_clk);
    chk(req_ready === 1'b0, "both message slots full");
    for (int m = 1; m < 3; m++)
      for (int s = 0; s < 4; s++)
        tx_check((8 * (m + 1) + s) * 51 + 8, 1, 4'(m), 4'(s));
    chk(n_seq_err == 1, "no order error on good blocks");
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_idle();
    t_seq_err();
    t_two_msgs();
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    $display("mismatch at %0t: watchdog expired", $time);
    n_errors++;
    tally_and_finish();
  end
endmodule
